// ==== verilog/sysref_window_pkg.sv ====
package sysref_window_pkg;
    // Register byte offsets
    localparam logic [7:0] OFFSET_PHASE_STATUS_LOW = 8'h2C;
    localparam logic [7:0] OFFSET_PHASE_STATUS_MID = 8'h2D;
    localparam logic [7:0] OFFSET_PHASE_STATUS_HIGH = 8'h2E;
    localparam logic [7:0] OFFSET_CAPTURE_CONTROL = 8'h2F;
    localparam logic [7:0] OFFSET_STATUS_CLEAR = 8'h30;
    // Control field positions
    localparam int SELECT_LSB = 0;
    localparam int SELECT_WIDTH = 4;
    localparam int FINE_STEP_BIT = 4;
    // Instance counts and the two end instances
    localparam int INSTANCE_COUNT = 24;
    localparam int SELECTABLE_COUNT = 16;
    localparam int FIRST_INSTANCE = 0;
    localparam int LAST_INSTANCE = 23;
    // Values after reset
    localparam logic [3:0] SELECT_RESET = 4'h0;
    localparam logic FINE_STEP_RESET = 1'b1;
    localparam logic [23:0] STATUS_RESET = 24'h800001;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage : sysref_window_pkg

// ==== verilog/sysref_window_capture.sv ====
// Notes on behaviour
// - SYSREF caught on one deterministic clock edge
// - Candidate instances are delayed clock copies
// - Status bit one marks marginal instance
// - Status is 24 bits, low delay low
// - Bits 0 and 23 always read one
// - Select index chooses the capturing instance
// - Only instances 0 to 15 selectable
// - Step control zero coarse, one fine
`timescale 1ns/100ps
`default_nettype none
module sysref_window_capture
    import sysref_window_pkg::*;
#(
    parameter int TAPS = INSTANCE_COUNT
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [TAPS-1:0] sysref_tap_sample,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_write_data,
    output logic [7:0] reg_read_data,
    output logic fine_delay_step,
    output logic [3:0] capture_phase_select,
    output logic sysref_captured,
    output logic sysref_capture_pulse
);

    // Number of instances the select field can name
    localparam int SELECT_SPAN = 1 << SELECT_WIDTH;

    // Elaboration checks: the register map holds exactly 24 status bits, and
    // the 4-bit select field must address exactly the first 16 of them
    if (TAPS != INSTANCE_COUNT)
    begin : gen_bad_taps
        $error("sysref_window_capture: TAPS must equal 24");
    end
    if (SELECT_SPAN != SELECTABLE_COUNT)
    begin : gen_bad_select
        $error("sysref_window_capture: select field must span 16 instances");
    end
    if (SELECTABLE_COUNT > TAPS)
    begin : gen_bad_span
        $error("sysref_window_capture: more selectable instances than taps");
    end

    typedef struct packed {
        logic [TAPS-1:0] sync_first; // First synchroniser stage
        logic [TAPS-1:0] sync_second; // Second synchroniser stage
        logic [TAPS-1:0] sync_third; // Third synchroniser stage
        logic [TAPS-1:0] tap_stable; // Filtered level per instance
        logic [TAPS-1:0] phase_status; // Sticky marginal marks
        logic [3:0] select; // Chosen capture instance
        logic fine_step; // Delay step size, 1 fine
        logic captured; // SYSREF through the chosen instance
        logic capture_pulse; // One cycle, the cycle before capture rises
        logic [7:0] read_data; // Registered read answer
    } state_type;

    state_type state;
    state_type next_state;
    logic [TAPS-1:0] marginal; // Instances flagged in this cycle
    logic [TAPS-1:0] tap_next; // Filtered level each instance will hold next
    logic selected_now; // Filtered level of the selected instance
    logic selected_next; // Its level one edge later

    // The delay chain itself lives outside this block. It hands us one sample
    // of SYSREF per delayed clock copy, already taken on those copies, so each
    // bit is asynchronous to sys_clk and must be filtered before comparison.
    // Limitation: a SYSREF edge that wanders by less than one step between
    // periods can flicker two neighbours; the sticky status keeps both marked,
    // which is the conservative answer for software choosing a capture point.

    // Per-instance stability filter and neighbour comparison
    genvar i;
    for (i = 0; i < TAPS; i = i + 1)
    begin : gen_tap
        // A change counts only once second and third stage agree
        assign tap_next[i] = (state.sync_second[i] == state.sync_third[i])
            ? state.sync_third[i] : state.tap_stable[i];
        if (i == FIRST_INSTANCE || i == LAST_INSTANCE)
        begin : gen_end
            // No neighbour on one side, so validity cannot be judged
            assign marginal[i] = 1'b1;
        end
        else
        begin : gen_mid
            // SYSREF edge lies between this instance and a neighbour
            assign marginal[i] = (state.tap_stable[i] != state.tap_stable[i-1])
                || (state.tap_stable[i] != state.tap_stable[i+1]);
        end
    end

    // Selected instance, picked once so capture and pulse agree on the tap
    assign selected_now = state.tap_stable[state.select];
    assign selected_next = tap_next[state.select];

    // Next-state logic for the whole block
    always_comb
    begin
        next_state = state;

        // Three stage synchroniser per delayed instance sample
        next_state.sync_first = sysref_tap_sample;
        next_state.sync_second = state.sync_first;
        next_state.sync_third = state.sync_second;
        next_state.tap_stable = tap_next;

        // Sticky marginal marks. A clear and a new mark in the same cycle
        // leave the mark set, so software never misses a marginal instance.
        if (reg_write && reg_addr == OFFSET_STATUS_CLEAR)
        begin
            next_state.phase_status = STATUS_RESET | marginal;
        end
        else
        begin
            next_state.phase_status = state.phase_status | marginal;
        end

        // Control register. Bits 7:5 are ignored; the 4-bit select field
        // cannot name an instance above 15, so no range check is needed
        if (reg_write && reg_addr == OFFSET_CAPTURE_CONTROL)
        begin
            next_state.select = reg_write_data[SELECT_LSB +: SELECT_WIDTH];
            next_state.fine_step = reg_write_data[FINE_STEP_BIT];
        end

        // Capture through the chosen instance on the device clock edge
        next_state.captured = selected_now;
        next_state.capture_pulse = selected_next && !selected_now;

        // Registered read answer, one cycle after the strobe; it falls back
        // to zero so a stale byte is never mistaken for a fresh read
        next_state.read_data = READ_UNMAPPED;
        if (reg_read)
        begin
            case (reg_addr)
                OFFSET_PHASE_STATUS_LOW:
                begin
                    next_state.read_data = state.phase_status[7:0];
                end
                OFFSET_PHASE_STATUS_MID:
                begin
                    next_state.read_data = state.phase_status[15:8];
                end
                OFFSET_PHASE_STATUS_HIGH:
                begin
                    next_state.read_data = state.phase_status[23:16];
                end
                OFFSET_CAPTURE_CONTROL:
                begin
                    next_state.read_data = {3'h0, state.fine_step, state.select};
                end
                default:
                begin
                    next_state.read_data = READ_UNMAPPED;
                end
            endcase
        end
    end

    // Reset brings the status back to its two end marks only. The select
    // returns to instance 0, so the chosen value must be written again after
    // every power-up; the block keeps nothing across a reset on purpose.
    // Fine steps are the default because they resolve the edge best at the
    // usual clock rates; coarse steps are for slow clocks only.

    // State register with synchronous reset
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state <= '0;
            state.phase_status <= STATUS_RESET;
            state.select <= SELECT_RESET;
            state.fine_step <= FINE_STEP_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Outputs straight from flip-flops
    assign reg_read_data = state.read_data;
    assign fine_delay_step = state.fine_step;
    assign capture_phase_select = state.select;
    assign sysref_captured = state.captured;
    assign sysref_capture_pulse = state.capture_pulse;

endmodule : sysref_window_capture
`default_nettype wire

// ==== test/sysref_window_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module sysref_window_props import sysref_window_pkg::*; #(parameter int TAPS = INSTANCE_COUNT)
(input wire logic sys_clk, sys_rst, reg_write, reg_read, fine_delay_step, sysref_captured,
    input wire logic sysref_capture_pulse, input wire logic [TAPS-1:0] sysref_tap_sample,
    input wire logic [7:0] reg_addr, reg_write_data, reg_read_data,
    input wire logic [3:0] capture_phase_select);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Accesses, and a quiet stretch long enough to clear the synchronisers
    sequence rd_at(logic [7:0] a); reg_read && reg_addr == a; endsequence
    sequence ctl_wr; reg_write && reg_addr == OFFSET_CAPTURE_CONTROL; endsequence
    sequence quiet; ($stable(sysref_tap_sample) && $stable(capture_phase_select))[*8]; endsequence
    chk_low_end: assert property (rd_at(8'h2C) |=> reg_read_data[0]) else $error("end");
    chk_high_end: assert property (rd_at(8'h2E) |=> reg_read_data[7]) else $error("end");
    chk_idle_zero: assert property (!reg_read |=> reg_read_data == 8'h00) else $error("idle");
    chk_sel_set: assert property (ctl_wr |=>
        capture_phase_select == $past(reg_write_data[3:0])) else $error("select");
    chk_step_set: assert property (ctl_wr |=>
        fine_delay_step == $past(reg_write_data[4])) else $error("step");
    chk_ctl_read: assert property (rd_at(8'h2F) |=>
        reg_read_data[4:0] == {$past(fine_delay_step), $past(capture_phase_select)})
        else $error("ctl");
    chk_capture_tap: assert property (quiet |->
        sysref_captured == sysref_tap_sample[capture_phase_select]) else $error("capture");
    chk_pulse_once: assert property (sysref_capture_pulse |=> !sysref_capture_pulse)
        else $error("pulse");
    chk_pulse_level: assert property (sysref_capture_pulse |=> sysref_captured)
        else $error("pulse level");
endmodule : sysref_window_props
bind sysref_window_capture sysref_window_props #(.TAPS(TAPS)) i_props (.*);
`default_nettype wire

// ==== test/clock_source_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module clock_source_model #(parameter int HALF = 16)
    (input wire logic sys_clk, run, input wire logic [4:0] edge_pos, output logic [23:0] taps);
    int cnt = 0;
    logic lvl = 1'b0, old = 1'b0;
    // Periodic reference, whole clocks per half period
    always @(posedge sys_clk)
    begin
        old <= lvl;
        cnt <= run ? (cnt + 1) % HALF : 0;
        if (run && cnt == HALF - 1) lvl <= !lvl;
    end
    // Taps below edge_pos see the old level one clock longer
    always_comb for (int i = 0; i < 24; i++) taps[i] = (i < edge_pos) ? old : lvl;
endmodule : clock_source_model
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import sysref_window_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, run = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_write_data = 8'h00, reg_read_data, b0, b1, b2;
    logic fine_delay_step, sysref_captured, sysref_capture_pulse;
    logic [3:0] capture_phase_select;
    logic [23:0] sysref_tap_sample;
    logic [4:0] edge_pos = 5'h00;
    int miscompares = 0, checks = 0, cyc = 0;
    initial forever #10 sys_clk = !sys_clk;
    sysref_window_capture i_sysref_window_capture (.*);
    clock_source_model i_clock_source_model (.sys_clk, .run, .edge_pos, .taps(sysref_tap_sample));
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {reg_addr, reg_write_data, reg_write} <= {a, d, 1'b1};
        @(posedge sys_clk);
        reg_write <= 1'b0;
        @(negedge sys_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge sys_clk);
        {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(negedge sys_clk);
        q = reg_read_data;
    endtask : rd
    // Status bytes are read one by one; nothing latches them together
    task automatic status(input logic [23:0] exp);
        rd(8'h2C, b0);
        rd(8'h2D, b1);
        rd(8'h2E, b2);
        cmp({b2, b1, b0}, exp);
    endtask : status
    task automatic go(input logic r, input logic [4:0] e);
        @(posedge sys_clk);
        {run, edge_pos} <= {r, e};
        repeat (60) @(posedge sys_clk);
    endtask : go
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    // Hang guard, far beyond the few hundred cycles the tests need
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin miscompares++; test_done(); end
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wr(8'h2C, 8'hFF);
        status(24'h800001);
        wr(OFFSET_CAPTURE_CONTROL, 8'h0F);
        cmp({fine_delay_step, capture_phase_select}, 5'h0F);
        rd(OFFSET_CAPTURE_CONTROL, b0);
        cmp(b0, 8'h0F);
        rd(8'h31, b0);
        cmp(b0, 8'h00);
        $display("registers done");
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        cmp({fine_delay_step, capture_phase_select, reg_read_data}, 13'h1000);
        status(24'h800001);
        $display("reset done");
        wr(OFFSET_CAPTURE_CONTROL, 8'h15);
        go(1'b1, 5'h0A);
        status(24'h800601);
        go(1'b0, 5'h14);
        cmp(sysref_captured, sysref_tap_sample[5]);
        wr(OFFSET_STATUS_CLEAR, 8'h00);
        status(24'h800001);
        go(1'b1, 5'h14);
        status(24'h980001);
        $display("window done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
